// >>> clr_pkg.sv
package clr_pkg;
  localparam int CLR_NUM_CNT = 3;
  localparam int CLR_ADDR_W = 18;
  localparam int CLR_IDX_W = 16;
  localparam int CLR_COUNT_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [15:0] CLR_IDX_CNT [CLR_NUM_CNT] = '{
    16'hF040, 16'hF041, 16'hF042};
  localparam logic [15:0] CLR_IDX_CMD = 16'hF043;
  localparam logic [1:0] CLR_ADDR_ALIGN = 2'h0;
  // Control word fields
  localparam int CLR_SEL_HI = 7;
  localparam int CLR_SEL_LO = 6;
  localparam int CLR_RW_HI = 5;
  localparam int CLR_RW_LO = 4;
  localparam int CLR_MODE_HI = 3;
  localparam int CLR_MODE_LO = 1;
  localparam int CLR_FMT_BIT = 0;
  localparam logic [1:0] CLR_SEL_READBACK = 2'h3;
  localparam logic [1:0] CLR_RW_LATCH = 2'h0;
  localparam logic [1:0] CLR_RW_LSB = 2'h1;
  localparam logic [1:0] CLR_RW_MSB = 2'h2;
  localparam logic [1:0] CLR_RW_BOTH = 2'h3;
  // Read-back fields
  localparam int CLR_RB_COUNT_BIT = 5;
  localparam int CLR_RB_STAT_BIT = 4;
  localparam int CLR_RB_SEL_BASE = 1;
  // Reset configuration
  localparam logic [1:0] CLR_RST_ORDER = 2'h1;
  localparam logic [2:0] CLR_RST_MODE = 3'h0;
  localparam logic CLR_RST_FMT = 1'b0;
  localparam logic [7:0] CLR_BYTE_ZERO = 8'h00;
  localparam logic [15:0] CLR_COUNT_ZERO = 16'h0000;
endpackage

// >>> clr_counter_latch_readback.sv
// Summary of operation
// - Counter-latch command copies live count to a holding latch.
// - Latched count held until fully read or counter reprogrammed.
// - Repeated latch commands before a read are ignored.
// - Port reads follow byte order: low, high, or low then high.
// - Other accesses may sit between the two byte reads of a count.
// - Read and write byte sequencing are tracked independently.
// - Read data carries one count byte on bits 7 to 0.
// - One read-back write may latch count and status of any counters.
// - Read-back bit 5 low latches counts of selected counters.
// - Read-back bit 4 low latches status of selected counters.
// - Read-back bits 3, 2, 1 select counters 2, 1, 0.
// - Status reports mode, format, byte order and pending-load state.
// - Select 11 is read-back; other selects with bits 5-4 zero latch.
// - Both latched: status read first, then count, then live values.
// - Status: bit 7 output, bit 6 pending load, order, mode, format.
// - Read-back parts hitting already latched items are ignored per item.
module clr_counter_latch_readback
  import clr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CLR_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [CLR_COUNT_W-1:0] live_count0_i,
  input wire logic [CLR_COUNT_W-1:0] live_count1_i,
  input wire logic [CLR_COUNT_W-1:0] live_count2_i,
  input wire logic counter_output_pin0_i,
  input wire logic counter_output_pin1_i,
  input wire logic counter_output_pin2_i,
  input wire logic count_pending_flag0_i,
  input wire logic count_pending_flag1_i,
  input wire logic count_pending_flag2_i,
  output logic [CLR_NUM_CNT-1:0] load_strobe_o,
  output logic load_high_o,
  output logic [7:0] load_data_o,
  output logic [CLR_NUM_CNT-1:0] cfg_strobe_o,
  output logic [7:0] cfg_data_o
);

  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  wire logic rst_b = rst_sync_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Per-counter inputs as arrays
  logic [CLR_COUNT_W-1:0] live [CLR_NUM_CNT];
  logic out_lvl [CLR_NUM_CNT];
  logic pend [CLR_NUM_CNT];

  assign live[0] = live_count0_i;
  assign live[1] = live_count1_i;
  assign live[2] = live_count2_i;

  assign out_lvl[0] = counter_output_pin0_i;
  assign out_lvl[1] = counter_output_pin1_i;
  assign out_lvl[2] = counter_output_pin2_i;

  assign pend[0] = count_pending_flag0_i;
  assign pend[1] = count_pending_flag1_i;
  assign pend[2] = count_pending_flag2_i;

  // APB decode
  logic addr_ok;
  logic [CLR_IDX_W-1:0] idx;
  logic setup;
  logic rd_acc;
  logic wr_acc;
  logic cmd_hit;
  logic cmd_wr;
  logic [7:0] cmd;
  logic [1:0] cmd_sel;
  logic [1:0] cmd_rw;
  logic is_rb;
  logic lane0;

  // Word-aligned accesses only; others get a slave error
  assign addr_ok = (paddr_i[1:0] == CLR_ADDR_ALIGN);
  assign idx = paddr_i[CLR_ADDR_W-1:2];
  assign setup = psel_i && !penable_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign lane0 = pstrb_i[0];
  assign cmd_hit = addr_ok && (idx == CLR_IDX_CMD);
  assign cmd_wr = wr_acc && cmd_hit && lane0;
  assign cmd = pwdata_i[7:0];
  assign cmd_sel = cmd[CLR_SEL_HI:CLR_SEL_LO];
  assign cmd_rw = cmd[CLR_RW_HI:CLR_RW_LO];
  assign is_rb = (cmd_sel == CLR_SEL_READBACK);

  // Per-counter decode and read byte
  logic [CLR_NUM_CNT-1:0] port_hit;
  logic [CLR_NUM_CNT-1:0] rd_fire;
  logic [CLR_NUM_CNT-1:0] wr_fire;
  logic [CLR_NUM_CNT-1:0] cfg_wr;
  logic [CLR_NUM_CNT-1:0] wr_high;
  logic [7:0] rd_byte [CLR_NUM_CNT];

  genvar g;
  generate
    for (g = 0; g < CLR_NUM_CNT; g++) begin : g_cnt
      logic [1:0] order_reg;
      logic [2:0] mode_reg;
      logic fmt_reg;
      logic cnt_lat_reg;
      logic st_lat_reg;
      logic [CLR_COUNT_W-1:0] cnt_hold_reg;
      logic [7:0] st_hold_reg;
      logic rd_ptr_reg;
      logic wr_ptr_reg;

      logic own;
      logic cl_cmd;
      logic rb_cnt;
      logic rb_st;
      logic both;
      logic hi_sel;
      logic last_rd;
      logic [CLR_COUNT_W-1:0] src;

      // Command decode for this counter
      assign own = (cmd_sel == 2'(g));
      assign port_hit[g] = addr_ok && (idx == CLR_IDX_CNT[g]);
      assign rd_fire[g] = rd_acc && port_hit[g];
      assign wr_fire[g] = wr_acc && port_hit[g] && lane0;
      assign cfg_wr[g] = cmd_wr && !is_rb && own
        && (cmd_rw != CLR_RW_LATCH);
      assign cl_cmd = cmd_wr && !is_rb && own
        && (cmd_rw == CLR_RW_LATCH);
      assign rb_cnt = cmd_wr && is_rb && cmd[CLR_RB_SEL_BASE+g]
        && !cmd[CLR_RB_COUNT_BIT];
      assign rb_st = cmd_wr && is_rb && cmd[CLR_RB_SEL_BASE+g]
        && !cmd[CLR_RB_STAT_BIT];

      // Byte pointers pick the byte in two-byte order
      assign both = (order_reg == CLR_RW_BOTH);
      assign hi_sel = (order_reg == CLR_RW_MSB)
        || (both && rd_ptr_reg);
      assign last_rd = !both || rd_ptr_reg;
      assign src = cnt_lat_reg ? cnt_hold_reg : live[g];

      // Status first, then count bytes in programmed order
      assign rd_byte[g] = st_lat_reg ? st_hold_reg
        : (hi_sel ? src[15:8] : src[7:0]);
      assign wr_high[g] = (order_reg == CLR_RW_MSB)
        || (both && wr_ptr_reg);

      // Programmed byte order, mode and format
      always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
          order_reg <= CLR_RST_ORDER;
          mode_reg <= CLR_RST_MODE;
          fmt_reg <= CLR_RST_FMT;
        end else if (cfg_wr[g]) begin
          order_reg <= cmd_rw;
          mode_reg <= cmd[CLR_MODE_HI:CLR_MODE_LO];
          fmt_reg <= cmd[CLR_FMT_BIT];
        end
      end

      // Count latch; running counter is only sampled
      always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
          cnt_lat_reg <= 1'b0;
          cnt_hold_reg <= CLR_COUNT_ZERO;
        end else if (cfg_wr[g]) begin
          cnt_lat_reg <= 1'b0;
        end else if (rd_fire[g] && !st_lat_reg && last_rd) begin
          cnt_lat_reg <= 1'b0;
        end else if ((cl_cmd || rb_cnt) && !cnt_lat_reg) begin
          cnt_lat_reg <= 1'b1;
          cnt_hold_reg <= live[g];
        end
      end

      // Status latch, read ahead of any count byte
      always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
          st_lat_reg <= 1'b0;
          st_hold_reg <= CLR_BYTE_ZERO;
        end else if (cfg_wr[g]) begin
          st_lat_reg <= 1'b0;
        end else if (rd_fire[g] && st_lat_reg) begin
          st_lat_reg <= 1'b0;
        end else if (rb_st && !st_lat_reg) begin
          st_lat_reg <= 1'b1;
          st_hold_reg <= {out_lvl[g], pend[g], order_reg, mode_reg,
                          fmt_reg};
        end
      end

      // Read byte pointer; status reads leave it alone
      always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
          rd_ptr_reg <= 1'b0;
        end else if (cfg_wr[g]) begin
          rd_ptr_reg <= 1'b0;
        end else if (rd_fire[g] && !st_lat_reg && both) begin
          rd_ptr_reg <= !rd_ptr_reg;
        end
      end

      // Write byte pointer, apart from the read one
      always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
          wr_ptr_reg <= 1'b0;
        end else if (cfg_wr[g]) begin
          wr_ptr_reg <= 1'b0;
        end else if (wr_fire[g] && both) begin
          wr_ptr_reg <= !wr_ptr_reg;
        end
      end
    end
  endgenerate

  // Read data and error are prepared in setup, presented in access
  logic [7:0] rd_next;
  logic err_next;

  always_comb begin
    rd_next = CLR_BYTE_ZERO;
    err_next = !(cmd_hit || (|port_hit));
    for (int i = 0; i < CLR_NUM_CNT; i++) begin
      if (port_hit[i]) begin
        rd_next = rd_byte[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o <= {24'h000000, pwrite_i ? CLR_BYTE_ZERO : rd_next};
      pslverr_o <= err_next;
    end
  end

  // No wait states
  assign pready_o = 1'b1;

  // Byte writes to the counting logic
  logic high_next;

  always_comb begin
    high_next = 1'b0;
    for (int i = 0; i < CLR_NUM_CNT; i++) begin
      if (wr_fire[i]) begin
        high_next = wr_high[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      load_strobe_o <= '0;
      load_high_o <= 1'b0;
      load_data_o <= CLR_BYTE_ZERO;
    end else begin
      load_strobe_o <= wr_fire;
      if (|wr_fire) begin
        load_high_o <= high_next;
        load_data_o <= pwdata_i[7:0];
      end
    end
  end

  // Control words on to the counting logic
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cfg_strobe_o <= '0;
      cfg_data_o <= CLR_BYTE_ZERO;
    end else begin
      cfg_strobe_o <= cfg_wr;
      if (|cfg_wr) begin
        cfg_data_o <= cmd;
      end
    end
  end

endmodule // clr_counter_latch_readback

// >>> clr_latch_asserts.sv
module clr_latch_asserts
  import clr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CLR_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic [CLR_NUM_CNT-1:0] load_strobe_o,
  input wire logic [7:0] load_data_o,
  input wire logic [CLR_NUM_CNT-1:0] cfg_strobe_o,
  input wire logic [7:0] cfg_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr;
  logic wc;
  logic wp;
  assign wr = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
  assign wc = wr & (paddr_i == {CLR_IDX_CMD, CLR_ADDR_ALIGN});
  assign wp = wr & (paddr_i[17:4] == 14'h3C10) & (paddr_i[3:2] != 2'h3)
    & (paddr_i[1:0] == 2'h0);
  property p_rd;
    psel_i && penable_i && !pwrite_i |-> prdata_o[31:8] == 24'h000000;
  endproperty
  a_rd: assert property (p_rd) else $error("rd high bits");
  property p_ld;
    |load_strobe_o |-> $past(wr) && load_data_o == $past(pwdata_i[7:0]);
  endproperty
  a_ld: assert property (p_ld) else $error("load cause");
  property p_pulse;
    |load_strobe_o |=> load_strobe_o == 3'h0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("load width");
  property p_pick;
    wp |=> load_strobe_o == 3'h1 << $past(paddr_i[3:2]);
  endproperty
  a_pick: assert property (p_pick) else $error("load pick");
  property p_quiet;
    wc |=> load_strobe_o == 3'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("cmd loads");
  property p_rb;
    wc && pwdata_i[7:6] == 2'h3 |=> cfg_strobe_o == 3'h0;
  endproperty
  a_rb: assert property (p_rb) else $error("readback cfg");
  property p_lat;
    wc && pwdata_i[5:4] == 2'h0 |=> cfg_strobe_o == 3'h0;
  endproperty
  a_lat: assert property (p_lat) else $error("latch cfg");
  property p_cfg;
    wc && pwdata_i[7:6] != 2'h3 && pwdata_i[5:4] != 2'h0 |=>
      cfg_strobe_o == 3'h1 << $past(pwdata_i[7:6]) &&
      cfg_data_o == $past(pwdata_i[7:0]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg word");
endmodule // clr_latch_asserts

bind clr_counter_latch_readback clr_latch_asserts chk_u (.clk_i, .rst_b_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
  .pready_o, .load_strobe_o, .load_data_o, .cfg_strobe_o, .cfg_data_o);

// >>> clr_count_model.sv
module clr_count_model
  import clr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [CLR_NUM_CNT-1:0] load_strobe_i,
  output logic [3*CLR_COUNT_W-1:0] live_o,
  output logic [CLR_NUM_CNT-1:0] out_o,
  output logic [CLR_NUM_CNT-1:0] pend_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tick_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_reg <= 16'h0000;
      pend_o <= 3'h0;
    end else begin
      tick_reg <= tick_reg + 16'h0107;
      pend_o <= pend_o ^ load_strobe_i;
    end
  end
  assign live_o = {tick_reg + 16'h2B3D, tick_reg + 16'h91E7, tick_reg};
  assign out_o = tick_reg[6:4];
endmodule // clr_count_model

// >>> tb_counter_latch_readback.sv
module tb_counter_latch_readback
  import clr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic load_high_o, err;
  logic [17:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic [3:0] pstrb_i;
  logic [47:0] live;
  logic [2:0] outp, pend, load_strobe_o, cfg_strobe_o;
  logic [7:0] load_data_o, cfg_data_o, rd_v, sv [3], cs [3];
  logic [15:0] lv [3], cv [3];
  logic [1:0] ord [3];
  logic [3:0] md [3];
  int seed = 32'hf69a;
  int mismatches = 0;
  int n_tests = 0;
  int i, n;
  localparam logic [17:0] CMD = {CLR_IDX_CMD, CLR_ADDR_ALIGN};
  clr_counter_latch_readback dut_u (.clk_i, .rst_b_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
    .pslverr_o, .live_count0_i(live[15:0]), .live_count1_i(live[31:16]),
    .live_count2_i(live[47:32]), .counter_output_pin0_i(outp[0]),
    .counter_output_pin1_i(outp[1]), .counter_output_pin2_i(outp[2]),
    .count_pending_flag0_i(pend[0]), .count_pending_flag1_i(pend[1]),
    .count_pending_flag2_i(pend[2]), .load_strobe_o, .load_high_o,
    .load_data_o, .cfg_strobe_o, .cfg_data_o);
  clr_count_model model_u (.clk_i, .rst_b_i, .load_strobe_i(load_strobe_o),
    .live_o(live), .out_o(outp), .pend_o(pend));
  always #4 clk_i = ~clk_i;
  function automatic logic [17:0] adr(input int c);
    return {CLR_IDX_CNT[c], CLR_ADDR_ALIGN};
  endfunction
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [17:0] a,
    input logic [7:0] d);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    #1;
    // Values that a command taken at the coming edge captures
    for (k = 0; k < 3; k++) begin
      lv[k] = live[16*k +: 16];
      sv[k] = {outp[k], pend[k], ord[k], md[k]};
    end
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    rd_v = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic rdcnt(input int c);
    if (ord[c] != 2'h2) begin
      xfer(1'b0, adr(c), 8'h00);
      chk(rd_v, cv[c][7:0]);
    end
    if (ord[c] == 2'h3) begin
      xfer(1'b1, adr(c), r[15:8]);
      xfer(1'b0, 18'h00000, 8'h00);
      chk({7'h00, err}, 8'h01);
      chk({7'h00, load_high_o}, 8'h00);
    end
    if (ord[c] != 2'h1) begin
      xfer(1'b0, adr(c), 8'h00);
      chk(rd_v, cv[c][15:8]);
    end
    if (ord[c] == 2'h3) begin
      xfer(1'b1, adr(c), r[23:16]);
      @(posedge clk_i);
      chk({7'h00, load_high_o}, 8'h01);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    pstrb_i = 4'hF;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 9; i++) begin
      n = i % 3;
      r = $random(seed);
      ord[n] = 2'(i / 3 + 1);
      md[n] = r[3:0];
      xfer(1'b1, CMD, {2'(n), ord[n], md[n]});
      xfer(1'b1, CMD, {2'(n), 6'h00});
      cv[n] = lv[n];
      repeat (r[6:4]) @(posedge clk_i);
      xfer(1'b1, CMD, {2'(n), 6'h00});
      rdcnt(n);
    end
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      if (i < 4) r[5:1] = {i[1:0], 3'h7};
      xfer(1'b1, CMD, {2'h3, r[5:1], 1'b0});
      cv = lv;
      cs = sv;
      xfer(1'b1, CMD, {2'h3, r[5:1], 1'b0});
      for (n = 0; n < 3; n++) begin
        if (r[n+1] && !r[4]) begin
          xfer(1'b0, adr(n), 8'h00);
          chk(rd_v, cs[n]);
        end
        if (r[n+1] && !r[5]) rdcnt(n);
      end
    end
    close_out();
  end
endmodule // tb_counter_latch_readback
